// ### src/fsq_pkg.sv
// Package for the file-system queue and direct-access mapping block
package fsq_pkg;
  localparam int FSQ_AW = 32;          // Window offset and length width
  localparam int FSQ_MAP_DEPTH = 4;    // Mapping table entries
  localparam int FSQ_MAP_IW = 2;
  localparam int FSQ_LOCK_POOL = 4;    // Lock resources
  localparam int FSQ_LOCK_CW = 3;
  localparam int FSQ_HDR_BYTES = 16;   // Response header size in bytes
  localparam logic [15:0] FSQ_NOTIFY_BUF_SIZE = 16'h0040;
  localparam logic [15:0] FSQ_MAX_PAYLOAD = FSQ_NOTIFY_BUF_SIZE - 16'(FSQ_HDR_BYTES);
  localparam logic [FSQ_AW-1:0] FSQ_WIN_SIZE = 32'h0010_0000;
  localparam logic [3:0] FSQ_SHM_ID = 4'h0;
  localparam logic [FSQ_AW-1:0] FSQ_ZERO = 32'h0000_0000;

  // Status codes
  localparam logic [3:0] FSQ_ST_OK = 4'h0;
  localparam logic [3:0] FSQ_ST_NO_LOCKS_AVAILABLE_ERROR = 4'h1;
  localparam logic [3:0] FSQ_ST_RANGE = 4'h2;
  localparam logic [3:0] FSQ_ST_NO_RESOURCE = 4'h3;
  localparam logic [3:0] FSQ_ST_ALIGN = 4'h4;
  localparam logic [3:0] FSQ_ST_NO_WINDOW = 4'h5;

  // Mapping operation codes
  localparam logic [1:0] FSQ_OP_SETUP = 2'h1;
  localparam logic [1:0] FSQ_OP_REMOVE = 2'h2;

  typedef struct packed {
    logic [FSQ_AW-1:0] woff;
    logic [FSQ_AW-1:0] len;
    logic [FSQ_AW-1:0] foff;
  } fsq_map_t;

  typedef struct packed {
    logic [15:0] tag;
    logic [3:0] status;
  } fsq_cpl_t;

  typedef struct packed {
    logic [15:0] msg_type;
    logic [15:0] len;
    logic [31:0] payload;
  } fsq_note_t;
endpackage

// ### src/fsq_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module fsq_skid #(
  parameter int W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  logic [W-1:0] mem_r [2];
  logic rd_r;
  logic wr_r;
  logic [1:0] cnt_r;
  wire push = i_valid && (cnt_r != 2'h2);
  wire pop = i_ready && (cnt_r != 2'h0);

  // Pointers and fill level; stalls from the drain side reach the source
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wr_r <= ~wr_r;
      if (pop) rd_r <= ~rd_r;
      cnt_r <= cnt_r + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) mem_r[wr_r] <= i_data;
  end

  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data = mem_r[rd_r];
endmodule

// ### src/fsq_map_entry.sv
// One mapping table slot with overlap classification
`timescale 1ns/1ps
module fsq_map_entry
  import fsq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic i_clr,
  input wire fsq_pkg::fsq_map_t i_new,
  input wire fsq_pkg::fsq_map_t i_req,
  output logic o_valid,
  output fsq_pkg::fsq_map_t o_ent,
  output logic o_exact,
  output logic o_overlap,
  output logic o_left,
  output logic o_right
);
  fsq_map_t ent_r;
  logic vld_r;
  wire [FSQ_AW-1:0] e_end = ent_r.woff + ent_r.len;
  wire [FSQ_AW-1:0] r_end = i_req.woff + i_req.len;

  // Write wins over clear so a split can reuse the freed slot
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      vld_r <= 1'b0;
      ent_r <= '0;
    end else if (i_wr) begin
      vld_r <= 1'b1;
      ent_r <= i_new;
    end else if (i_clr) begin
      vld_r <= 1'b0;
    end
  end

  assign o_valid = vld_r;
  assign o_ent = ent_r;
  assign o_exact = vld_r && (ent_r.woff == i_req.woff) && (ent_r.len == i_req.len);
  assign o_overlap = vld_r && (i_req.woff < e_end) && (ent_r.woff < r_end);
  assign o_left = ent_r.woff < i_req.woff;   // Residue below the request
  assign o_right = e_end > r_end;            // Residue above the request
endmodule

// ### src/fsq_core.sv
// File-system queue arbitration, notification delivery and mapping table
`timescale 1ns/1ps
// What this block does
// - Urgent queue is accepted every cycle it is offered, never blocked by normal traffic.
// - Normal queue runs in parallel; completions of both may interleave freely.
// - Notify message is header plus payload capped at buffer size minus header.
// - Lock notifications wait while no buffer is posted, then get delivered.
// - Lock pool is finite; an empty pool fails lock requests with lock error.
// - Optional mapping window appears as shared memory region zero.
// - Unmapped window ranges return undefined data.
// - A successful setup makes the file range reachable at the given offset.
// - Exact cover of an entry replaces it.
// - Partial cover by setup splits the old entry into one or two residues.
// - Partial remove splits the entry into one or two residues.
// - When entries run out, setup fails until a remove frees space.
// - Setup past the window end is rejected; overlaps are allowed.
// - Normal read and write service goes on regardless of the window.
// - Durability is signalled only after a sync following the write.
// - Both sides honour the negotiated mapping alignment.
// - Configured buffer size holds any notify message emitted.
module fsq_core
  import fsq_pkg::*;
#(
  parameter int MAP_DEPTH = FSQ_MAP_DEPTH,
  parameter int LOCK_POOL = FSQ_LOCK_POOL,
  parameter bit WINDOW_PRESENT = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Urgent queue
  input wire logic i_urg_valid,
  input wire logic [15:0] i_urg_tag,
  output logic o_urg_ready,
  output logic o_urg_cpl_valid,
  output fsq_pkg::fsq_cpl_t o_urg_cpl,
  // Normal request queue
  input wire logic i_req_valid,
  input wire logic [15:0] i_req_tag,
  input wire logic i_req_is_sync,
  output logic o_req_ready,
  input wire logic i_req_done,
  output logic o_req_cpl_valid,
  output fsq_pkg::fsq_cpl_t o_req_cpl,
  output logic o_durable,
  // Lock requests and releases
  input wire logic i_lock_req,
  input wire logic i_lock_rel,
  output logic o_lock_cpl_valid,
  output logic [3:0] o_lock_status,
  // Notifications
  input wire logic i_note_valid,
  input wire fsq_pkg::fsq_note_t i_note,
  output logic o_note_ready,
  input wire logic i_buf_avail,
  output logic o_note_wr,
  output fsq_pkg::fsq_note_t o_note_out,
  output logic [15:0] o_notify_buf_size,
  // Mapping requests
  input wire logic i_map_valid,
  input wire logic [1:0] i_map_op,
  input wire fsq_pkg::fsq_map_t i_map_req,
  input wire logic [FSQ_AW-1:0] i_align_mask,
  output logic o_map_ready,
  output logic o_map_cpl_valid,
  output logic [3:0] o_map_status,
  output logic o_shm_present,
  output logic [3:0] o_shm_id,
  // Window translation
  input wire logic [FSQ_AW-1:0] i_win_addr,
  output logic o_win_hit,
  output logic [FSQ_AW-1:0] o_win_foff
);
  // Urgent path: always ready, completion one cycle after acceptance
  logic urg_cpl_v_r;
  fsq_cpl_t urg_cpl_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      urg_cpl_v_r <= 1'b0;
      urg_cpl_r <= '0;
    end else begin
      urg_cpl_v_r <= i_urg_valid;
      urg_cpl_r <= '{tag: i_urg_tag, status: FSQ_ST_OK};
    end
  end
  assign o_urg_ready = 1'b1;
  assign o_urg_cpl_valid = urg_cpl_v_r;
  assign o_urg_cpl = urg_cpl_r;

  // Normal path: one request in flight, separate from the urgent path
  logic req_busy_r;
  logic req_sync_r;
  logic req_cpl_v_r;
  logic durable_r;
  fsq_cpl_t req_cpl_r;
  wire req_take = i_req_valid && !req_busy_r;
  wire req_fin = req_busy_r && i_req_done;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      req_busy_r <= 1'b0;
      req_sync_r <= 1'b0;
      req_cpl_v_r <= 1'b0;
      req_cpl_r <= '0;
      durable_r <= 1'b0;
    end else begin
      req_cpl_v_r <= req_fin;
      if (req_take) begin
        req_busy_r <= 1'b1;
        req_sync_r <= i_req_is_sync;
        req_cpl_r <= '{tag: i_req_tag, status: FSQ_ST_OK};
        durable_r <= 1'b0; // A new write voids earlier durability
      end else if (req_fin) begin
        req_busy_r <= 1'b0;
        durable_r <= req_sync_r;
      end
    end
  end
  assign o_req_ready = !req_busy_r;
  assign o_req_cpl_valid = req_cpl_v_r;
  assign o_req_cpl = req_cpl_r;
  assign o_durable = durable_r;

  // Lock pool: a release in the same cycle as a request keeps the count only while some locks are held and some are free
  logic [FSQ_LOCK_CW-1:0] locks_r;
  logic lock_cpl_v_r;
  logic [3:0] lock_st_r;
  wire lock_empty = (locks_r == FSQ_LOCK_CW'(LOCK_POOL));
  wire lock_grant = i_lock_req && !lock_empty;
  wire lock_free = i_lock_rel && (locks_r != '0);
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      locks_r <= '0;
      lock_cpl_v_r <= 1'b0;
      lock_st_r <= FSQ_ST_OK;
    end else begin
      locks_r <= locks_r + FSQ_LOCK_CW'(lock_grant) - FSQ_LOCK_CW'(lock_free);
      lock_cpl_v_r <= i_lock_req;
      lock_st_r <= lock_grant ? FSQ_ST_OK : FSQ_ST_NO_LOCKS_AVAILABLE_ERROR;
    end
  end
  assign o_lock_cpl_valid = lock_cpl_v_r;
  assign o_lock_status = lock_st_r;

  // Notifications queue in the buffer while no driver buffer is posted
  logic nb_valid;
  fsq_note_t nb_data;
  fsq_note_t note_in;
  logic note_wr_r;
  fsq_note_t note_out_r;
  // Clip payload length so header plus payload fits the posted buffer
  assign note_in = '{msg_type: i_note.msg_type, payload: i_note.payload,
                     len: (i_note.len > FSQ_MAX_PAYLOAD) ? FSQ_MAX_PAYLOAD : i_note.len};
  fsq_skid #(.W($bits(fsq_note_t))) u_note_buf (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_valid(i_note_valid),
    .o_ready(o_note_ready),
    .i_data(note_in),
    .o_valid(nb_valid),
    .i_ready(i_buf_avail),
    .o_data(nb_data)
  );
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      note_wr_r <= 1'b0;
      note_out_r <= '0;
    end else begin
      note_wr_r <= nb_valid && i_buf_avail;
      note_out_r <= nb_data;
    end
  end
  assign o_note_wr = note_wr_r;
  assign o_note_out = note_out_r;
  assign o_notify_buf_size = FSQ_NOTIFY_BUF_SIZE;
  assign o_shm_present = WINDOW_PRESENT;
  assign o_shm_id = FSQ_SHM_ID;

  // Mapping table
  logic [MAP_DEPTH-1:0] e_vld;
  logic [MAP_DEPTH-1:0] e_ovl;
  logic [MAP_DEPTH-1:0] e_left;
  logic [MAP_DEPTH-1:0] e_right;
  logic [MAP_DEPTH-1:0] e_wr;
  logic [MAP_DEPTH-1:0] e_clr;
  logic [MAP_DEPTH-1:0] e_hit;
  fsq_map_t e_ent [MAP_DEPTH];
  fsq_map_t e_new [MAP_DEPTH];
  fsq_map_t cur_r;

  typedef enum logic [3:0] {
    FSQ_S_IDLE = 4'h1,
    FSQ_S_SCAN = 4'h2,
    FSQ_S_INS = 4'h4,
    FSQ_S_DONE = 4'h8
  } fsq_state_t;
  fsq_state_t st_r;
  fsq_state_t st_nxt;
  logic [1:0] op_r;
  logic [3:0] mst_r;
  logic mcpl_r;

  genvar g;
  generate
    for (g = 0; g < MAP_DEPTH; g++) begin : g_ent
      fsq_map_entry u_ent (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_wr(e_wr[g]),
        .i_clr(e_clr[g]),
        .i_new(e_new[g]),
        .i_req(cur_r),
        .o_valid(e_vld[g]),
        .o_ent(e_ent[g]),
        .o_exact(),
        .o_overlap(e_ovl[g]),
        .o_left(e_left[g]),
        .o_right(e_right[g])
      );
      assign e_hit[g] = e_vld[g] && (i_win_addr >= e_ent[g].woff) &&
                        (i_win_addr - e_ent[g].woff < e_ent[g].len);
    end
  endgenerate

  // Scan state: first overlapping entry is cut, free slots found for residues
  logic scan_any;
  logic [FSQ_MAP_IW-1:0] scan_idx;
  logic [FSQ_MAP_IW-1:0] free_a;
  logic [2:0] free_cnt;
  always_comb begin
    scan_any = 1'b0;
    scan_idx = '0;
    free_a = '0;
    free_cnt = '0;
    for (int i = MAP_DEPTH - 1; i >= 0; i--) begin
      if (e_ovl[i]) begin
        scan_any = 1'b1;
        scan_idx = FSQ_MAP_IW'(i);
      end
      if (!e_vld[i]) begin
        free_a = FSQ_MAP_IW'(i);
        free_cnt = free_cnt + 3'h1;
      end
    end
  end

  wire fsq_map_t hit_e = e_ent[scan_idx];
  wire hit_l = e_left[scan_idx];
  wire hit_r = e_right[scan_idx];
  wire [FSQ_AW-1:0] req_end = cur_r.woff + cur_r.len;
  wire [FSQ_AW-1:0] hit_end = hit_e.woff + hit_e.len;
  // The cut slot itself is freed, so it counts as room for one residue
  wire [2:0] need = 3'(hit_l) + 3'(hit_r);
  wire split_fits = (free_cnt + 3'h1) >= need;
  wire fsq_map_t res_l = '{woff: hit_e.woff, len: cur_r.woff - hit_e.woff, foff: hit_e.foff};
  wire fsq_map_t res_r = '{woff: req_end, len: hit_end - req_end,
                           foff: hit_e.foff + (req_end - hit_e.woff)};
  // Setup checks: alignment, window end (with wrap), empty window option
  wire bad_align = ((i_map_req.woff | i_map_req.len | i_map_req.foff) & i_align_mask) != '0;
  wire [FSQ_AW:0] new_end = {1'b0, i_map_req.woff} + {1'b0, i_map_req.len};
  wire bad_range = new_end > {1'b0, FSQ_WIN_SIZE};
  wire take_map = (st_r == FSQ_S_IDLE) && i_map_valid;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FSQ_S_IDLE: if (take_map) st_nxt = FSQ_S_SCAN;
      FSQ_S_SCAN: if (mst_r != FSQ_ST_OK) st_nxt = FSQ_S_DONE;
                  else if (!scan_any) st_nxt = (op_r == FSQ_OP_SETUP) ? FSQ_S_INS : FSQ_S_DONE;
                  else if (!split_fits) st_nxt = FSQ_S_DONE;
      FSQ_S_INS: st_nxt = FSQ_S_DONE;
      FSQ_S_DONE: st_nxt = FSQ_S_IDLE;
      default: st_nxt = FSQ_S_IDLE;
    endcase
  end

  // Slot writes: one entry cut per scan cycle until no overlap remains
  always_comb begin
    e_wr = '0;
    e_clr = '0;
    for (int i = 0; i < MAP_DEPTH; i++) e_new[i] = res_l;
    if (st_r == FSQ_S_SCAN && mst_r == FSQ_ST_OK && scan_any && split_fits) begin
      e_clr[scan_idx] = 1'b1;
      if (hit_l) begin
        e_wr[scan_idx] = 1'b1;
        e_new[scan_idx] = res_l;
      end
      if (hit_r) begin
        if (hit_l) begin
          e_wr[free_a] = 1'b1;
          e_new[free_a] = res_r;
        end else begin
          e_wr[scan_idx] = 1'b1;
          e_new[scan_idx] = res_r;
        end
      end
    end else if (st_r == FSQ_S_INS && free_cnt != '0) begin
      e_wr[free_a] = 1'b1;
      e_new[free_a] = cur_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st_r <= FSQ_S_IDLE;
      cur_r <= '0;
      op_r <= '0;
      mst_r <= FSQ_ST_OK;
      mcpl_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mcpl_r <= (st_r == FSQ_S_DONE);
      if (take_map) begin
        cur_r <= i_map_req;
        op_r <= i_map_op;
        if (!WINDOW_PRESENT) mst_r <= FSQ_ST_NO_WINDOW;
        else if (bad_align) mst_r <= FSQ_ST_ALIGN;
        else if (i_map_op == FSQ_OP_SETUP && bad_range) mst_r <= FSQ_ST_RANGE;
        else mst_r <= FSQ_ST_OK;
      end else if (st_r == FSQ_S_SCAN && mst_r == FSQ_ST_OK && scan_any && !split_fits) begin
        mst_r <= FSQ_ST_NO_RESOURCE;
      end else if (st_r == FSQ_S_INS && free_cnt == '0) begin
        mst_r <= FSQ_ST_NO_RESOURCE;
      end
    end
  end
  assign o_map_ready = (st_r == FSQ_S_IDLE);
  assign o_map_cpl_valid = mcpl_r;
  assign o_map_status = mst_r;

  // Window translation; unmapped addresses return no defined offset
  logic win_hit_r;
  logic [FSQ_AW-1:0] win_foff_r;
  logic [FSQ_MAP_IW-1:0] hit_idx;
  always_comb begin
    hit_idx = '0;
    for (int i = MAP_DEPTH - 1; i >= 0; i--) if (e_hit[i]) hit_idx = FSQ_MAP_IW'(i);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      win_hit_r <= 1'b0;
      win_foff_r <= FSQ_ZERO;
    end else begin
      win_hit_r <= |e_hit;
      win_foff_r <= e_ent[hit_idx].foff + (i_win_addr - e_ent[hit_idx].woff);
    end
  end
  assign o_win_hit = win_hit_r;
  assign o_win_foff = win_foff_r;
endmodule

// ### dv/fsq_core_assertions.sv
// Concurrent checks on the queue and mapping block ports
`timescale 1ns/1ps
module fsq_core_assertions
  import fsq_pkg::*;
#(
  parameter int MAP_DEPTH = FSQ_MAP_DEPTH,
  parameter int LOCK_POOL = FSQ_LOCK_POOL
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_urg_valid,
  input wire logic [15:0] i_urg_tag,
  input wire logic o_urg_ready,
  input wire logic o_urg_cpl_valid,
  input wire fsq_pkg::fsq_cpl_t o_urg_cpl,
  input wire logic o_req_ready,
  input wire logic i_req_done,
  input wire logic o_req_cpl_valid,
  input wire logic i_buf_avail,
  input wire logic o_note_wr,
  input wire fsq_pkg::fsq_note_t o_note_out,
  input wire logic [15:0] o_notify_buf_size,
  input wire logic i_map_valid,
  input wire logic [1:0] i_map_op,
  input wire fsq_pkg::fsq_map_t i_map_req,
  input wire logic o_map_ready,
  input wire logic o_map_cpl_valid,
  input wire logic [3:0] o_map_status,
  input wire logic o_shm_present,
  input wire logic [3:0] o_shm_id
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  AST_URG_CPL: assert property (
    i_urg_valid |=> o_urg_cpl_valid && o_urg_cpl.tag == $past(i_urg_tag)
      && o_urg_cpl.status == FSQ_ST_OK)
    else $error("urgent completion missing or wrong");
  AST_URG_READY: assert property (
    i_urg_valid |-> o_urg_ready)
    else $error("urgent request refused");
  AST_REQ_CPL: assert property (
    i_req_done && !o_req_ready |=> o_req_cpl_valid && o_req_ready)
    else $error("normal completion late");
  AST_NOTE_LEN: assert property (
    o_note_wr |-> o_note_out.len <= FSQ_MAX_PAYLOAD)
    else $error("notify payload too long");
  AST_NOTE_HOLD: assert property (
    !i_buf_avail |=> !o_note_wr)
    else $error("notify written without a buffer");
  AST_BUF_SIZE: assert property (
    o_note_wr |-> o_notify_buf_size == FSQ_NOTIFY_BUF_SIZE
      && o_notify_buf_size >= 16'(FSQ_HDR_BYTES) + o_note_out.len)
    else $error("buffer size cannot hold message");
  AST_SHM_ID: assert property (
    o_shm_present |-> o_shm_id == FSQ_SHM_ID)
    else $error("window region id wrong");
  AST_MAP_RANGE: assert property (
    i_map_valid && o_map_ready && i_map_op == FSQ_OP_SETUP
      && ({1'b0, i_map_req.woff} + {1'b0, i_map_req.len} > {1'b0, FSQ_WIN_SIZE})
      |-> ##[1:20] o_map_cpl_valid && o_map_status != FSQ_ST_OK)
    else $error("setup past window end accepted");
endmodule

bind fsq_core fsq_core_assertions #(.MAP_DEPTH(MAP_DEPTH), .LOCK_POOL(LOCK_POOL)) u_fsq_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_urg_valid(i_urg_valid),
  .i_urg_tag(i_urg_tag), .o_urg_ready(o_urg_ready), .o_urg_cpl_valid(o_urg_cpl_valid),
  .o_urg_cpl(o_urg_cpl), .o_req_ready(o_req_ready), .i_req_done(i_req_done),
  .o_req_cpl_valid(o_req_cpl_valid), .i_buf_avail(i_buf_avail), .o_note_wr(o_note_wr),
  .o_note_out(o_note_out), .o_notify_buf_size(o_notify_buf_size),
  .i_map_valid(i_map_valid), .i_map_op(i_map_op), .i_map_req(i_map_req),
  .o_map_ready(o_map_ready), .o_map_cpl_valid(o_map_cpl_valid),
  .o_map_status(o_map_status), .o_shm_present(o_shm_present), .o_shm_id(o_shm_id)
);

// ### dv/fsq_drv_model.sv
// Driver-side model that posts notification buffers and collects notify messages
`timescale 1ns/1ps
module fsq_drv_model
  import fsq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_stall,
  input wire logic i_slow,
  input wire logic i_note_wr,
  input wire fsq_pkg::fsq_note_t i_note_out,
  output logic o_buf_avail,
  output int o_got,
  output fsq_pkg::fsq_note_t o_last
);
  // Each posted buffer is a full configured-size one; slow mode posts every other cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_buf_avail <= 1'b0;
      o_got <= 0;
      o_last <= '0;
    end else begin
      o_buf_avail <= !i_stall && !(i_slow && o_buf_avail);
      if (i_note_wr) begin
        o_got <= o_got + 1;
        o_last <= i_note_out;
      end
    end
  end
endmodule

// ### dv/fsq_core_bench.sv
// Self-checking bench for the queue and mapping block
`timescale 1ns/1ps
module fsq_core_bench;
  import fsq_pkg::*;
  localparam int LOCKS = 3;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic urg_valid = 1'b0, req_valid = 1'b0, req_sync = 1'b0, req_done = 1'b0;
  logic lock_req = 1'b0, lock_rel = 1'b0, note_valid = 1'b0, map_valid = 1'b0;
  logic stall = 1'b0, slow = 1'b0;
  logic [15:0] urg_tag = 16'h0, req_tag = 16'h0, buf_size;
  logic [1:0] map_op = 2'h0;
  logic [31:0] align_mask = 32'h0000_00ff, win_addr = 32'h0, win_foff;
  fsq_note_t note = '0, note_out, last;
  fsq_map_t map_req = '0;
  fsq_cpl_t urg_cpl, req_cpl;
  logic urg_ready, urg_cpl_valid, req_ready, req_cpl_valid, durable, lock_cpl_valid;
  logic note_ready, buf_avail, note_wr, map_ready, map_cpl_valid, shm_present, win_hit;
  logic [3:0] lock_status, map_status, shm_id;
  int got, n_mismatch = 0, samples_checked = 0, cycles = 0;

  fsq_core #(.MAP_DEPTH(FSQ_MAP_DEPTH), .LOCK_POOL(LOCKS), .WINDOW_PRESENT(1'b1)) dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_urg_valid(urg_valid), .i_urg_tag(urg_tag),
    .o_urg_ready(urg_ready), .o_urg_cpl_valid(urg_cpl_valid), .o_urg_cpl(urg_cpl),
    .i_req_valid(req_valid), .i_req_tag(req_tag), .i_req_is_sync(req_sync),
    .o_req_ready(req_ready), .i_req_done(req_done), .o_req_cpl_valid(req_cpl_valid),
    .o_req_cpl(req_cpl), .o_durable(durable), .i_lock_req(lock_req), .i_lock_rel(lock_rel),
    .o_lock_cpl_valid(lock_cpl_valid), .o_lock_status(lock_status),
    .i_note_valid(note_valid), .i_note(note), .o_note_ready(note_ready),
    .i_buf_avail(buf_avail), .o_note_wr(note_wr), .o_note_out(note_out),
    .o_notify_buf_size(buf_size), .i_map_valid(map_valid), .i_map_op(map_op),
    .i_map_req(map_req), .i_align_mask(align_mask), .o_map_ready(map_ready),
    .o_map_cpl_valid(map_cpl_valid), .o_map_status(map_status),
    .o_shm_present(shm_present), .o_shm_id(shm_id), .i_win_addr(win_addr),
    .o_win_hit(win_hit), .o_win_foff(win_foff)
  );

  fsq_drv_model u_drv (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_stall(stall), .i_slow(slow),
    .i_note_wr(note_wr), .i_note_out(note_out), .o_buf_avail(buf_avail), .o_got(got),
    .o_last(last)
  );

  // Clock, and a cycle ceiling that cuts a hang short
  always #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Normal request taken on the first edge, since the queue is idle
  task automatic req_start(input logic [15:0] t, input logic s);
    @(posedge i_clk_sys);
    req_valid <= 1'b1;
    req_tag <= t;
    req_sync <= s;
    @(posedge i_clk_sys);
    req_valid <= 1'b0;
    #1;
    chk(req_ready === 1'b0 && durable === 1'b0, "normal take");
  endtask

  task automatic req_finish(input logic [15:0] t, input logic s);
    @(posedge i_clk_sys);
    req_done <= 1'b1;
    @(posedge i_clk_sys);
    req_done <= 1'b0;
    #1;
    chk(req_cpl_valid === 1'b1 && req_cpl.tag === t && req_cpl.status === FSQ_ST_OK
      && durable === s, "normal cpl");
  endtask

  // Urgent requests back to back while a normal request is still in flight
  task automatic t_urgent_busy();
    req_start(16'h0a01, 1'b0);
    for (int i = 0; i <= 3; i++) begin
      @(posedge i_clk_sys);
      urg_valid <= (i < 3);
      urg_tag <= 16'h0b00 + 16'(i);
      if (i > 0) begin
        #1;
        chk(urg_cpl_valid === 1'b1 && urg_cpl.tag === 16'h0b00 + 16'(i - 1)
          && urg_cpl.status === FSQ_ST_OK, "urgent cpl");
      end
    end
    chk(req_ready === 1'b0, "normal still busy");
    req_finish(16'h0a01, 1'b0);
    req_start(16'h0a02, 1'b1);
    req_finish(16'h0a02, 1'b1);
    req_start(16'h0a03, 1'b0);
    req_finish(16'h0a03, 1'b0);
  endtask

  task automatic lock_pulse(input logic q, input logic r);
    @(posedge i_clk_sys);
    lock_req <= q;
    lock_rel <= r;
    @(posedge i_clk_sys);
    lock_req <= 1'b0;
    lock_rel <= 1'b0;
    #1;
  endtask

  // Pool exhausted, then one release makes room again
  task automatic t_lock();
    for (int i = 0; i <= LOCKS; i++) begin
      lock_pulse(1'b1, 1'b0);
      chk(lock_cpl_valid === 1'b1 && lock_status === ((i < LOCKS) ? FSQ_ST_OK
        : FSQ_ST_NO_LOCKS_AVAILABLE_ERROR), "lock status");
    end
    lock_pulse(1'b0, 1'b1);
    lock_pulse(1'b1, 1'b0);
    chk(lock_status === FSQ_ST_OK, "lock after release");
  endtask

  task automatic note_push(input logic [15:0] l, input bit wait_take);
    @(posedge i_clk_sys);
    note_valid <= 1'b1;
    note <= {16'h0001, l, 16'h5a5a, l};
    if (wait_take) begin
      @(negedge i_clk_sys);
      while (note_ready !== 1'b1) @(negedge i_clk_sys);
      @(posedge i_clk_sys);
      note_valid <= 1'b0;
    end
  endtask

  // Fill the buffer while no driver buffer is posted, then drain slowly
  task automatic t_notify();
    @(posedge i_clk_sys);
    stall <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    note_push(16'h0008, 1'b1);
    note_push(16'h0010, 1'b1);
    note_push(16'h0064, 1'b0);
    repeat (4) @(negedge i_clk_sys);
    chk(note_ready === 1'b0 && got === 0, "notes held without buffer");
    @(posedge i_clk_sys);
    stall <= 1'b0;
    slow <= 1'b1;
    @(negedge i_clk_sys);
    while (note_ready !== 1'b1) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    note_valid <= 1'b0;
    for (int k = 0; k < 40 && got != 3; k++) @(posedge i_clk_sys);
    chk(got === 3 && last.len === FSQ_MAX_PAYLOAD && last.msg_type === 16'h0001
      && last.payload === 32'h5a5a_0064, "notes delivered, last clipped");
    slow <= 1'b0;
  endtask

  task automatic map_do(input logic [1:0] op, input logic [31:0] w, l, f, input logic [3:0] st);
    @(posedge i_clk_sys);
    map_valid <= 1'b1;
    map_op <= op;
    map_req <= {w, l, f};
    @(negedge i_clk_sys);
    while (map_ready !== 1'b1) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    map_valid <= 1'b0;
    for (int k = 0; k < 40 && map_cpl_valid !== 1'b1; k++) begin
      @(posedge i_clk_sys);
      #1;
    end
    chk(map_cpl_valid === 1'b1 && map_status === st, "mapping status");
  endtask

  task automatic win_chk(input logic [31:0] a, input logic hit, input logic [31:0] f);
    @(posedge i_clk_sys);
    win_addr <= a;
    @(posedge i_clk_sys);
    #1;
    chk(win_hit === hit && (!hit || win_foff === f), "window translation");
  endtask

  // Replace, split by setup, split by remove, run out of entries, refusals
  task automatic t_map();
    map_do(FSQ_OP_SETUP, 32'h0, 32'h1000, 32'h8000, FSQ_ST_OK);
    win_chk(32'h10, 1'b1, 32'h8010);
    map_do(FSQ_OP_SETUP, 32'h0, 32'h1000, 32'h2_0000, FSQ_ST_OK);
    win_chk(32'h10, 1'b1, 32'h2_0010);
    map_do(FSQ_OP_SETUP, 32'h400, 32'h400, 32'h5_0000, FSQ_ST_OK);
    win_chk(32'h100, 1'b1, 32'h2_0100);
    win_chk(32'h500, 1'b1, 32'h5_0100);
    win_chk(32'hc00, 1'b1, 32'h2_0c00);
    map_do(FSQ_OP_REMOVE, 32'h500, 32'h100, 32'h0, FSQ_ST_OK);
    win_chk(32'h500, 1'b0, 32'h0);
    win_chk(32'h480, 1'b1, 32'h5_0080);
    win_chk(32'h700, 1'b1, 32'h5_0300);
    map_do(FSQ_OP_SETUP, 32'h1_0000, 32'h100, 32'h0, FSQ_ST_NO_RESOURCE);
    map_do(FSQ_OP_REMOVE, 32'h0, 32'h400, 32'h0, FSQ_ST_OK);
    map_do(FSQ_OP_SETUP, 32'h1_0000, 32'h100, 32'h0, FSQ_ST_OK);
    win_chk(32'h1_0010, 1'b1, 32'h10);
    win_chk(32'h100, 1'b0, 32'h0);
    map_do(FSQ_OP_SETUP, 32'hf_f000, 32'h2000, 32'h0, FSQ_ST_RANGE);
    map_do(FSQ_OP_SETUP, 32'h2_0010, 32'h100, 32'h0, FSQ_ST_ALIGN);
  endtask

  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(negedge i_clk_sys);
    chk(req_ready === 1'b1 && map_ready === 1'b1 && note_ready === 1'b1 && urg_ready === 1'b1,
      "idle readies");
    chk(buf_size === FSQ_NOTIFY_BUF_SIZE, "buffer size");
    chk(shm_present === 1'b1 && shm_id === FSQ_SHM_ID, "window region id");
    t_urgent_busy();
    t_lock();
    t_notify();
    t_map();
    tally_and_finish();
  end
endmodule
